//--- core/cbs_map.svh
// constants for the bit, stack and return instruction slice
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH
// storage sizes
`define CBS_NUM_ACC 16
`define CBS_STK_DEPTH 32
`define CBS_SP_W 5
`define CBS_NUM_PFX 8
`define CBS_NUM_MOD 6
`define CBS_MOD_REGS 16
`define CBS_SYS_REGS 16
// apb register byte offsets
`define CBS_OFS_CTRL 12'h000
`define CBS_OFS_STATUS 12'h004
`define CBS_OFS_IP 12'h008
`define CBS_OFS_ACC 12'h00C
// control register fields and reset values
`define CBS_CTRL_EXEC 0
`define CBS_CTRL_RST 1'b1
// flags register (system module 8) fields
`define CBS_PSF_E 0
`define CBS_PSF_C 1
`define CBS_PSF_Z 2
`define CBS_PSF_S 3
// system module codes and indexes
`define CBS_SYS_MOD 4'h8
`define CBS_LAST_MOD 3'h5
`define CBS_SYS_AP 4'h0
`define CBS_SYS_PSF 4'h4
// opcode field values
`define CBS_NIB_ACCOP 4'hA
`define CBS_NIB_ACCREG 4'h9
`define CBS_NIB_PFX 4'hB
`define CBS_NIB_IPDST 4'hC
`define CBS_NIB_BITOP 4'h7
`define CBS_LOW_STK 7'h0D
`define CBS_DST_NUL 7'h76
`define CBS_DST_ACC 7'h0A
`define CBS_SRC_ACC 8'h0A
`define CBS_SRC_ACC_NOAP 8'h1A
`define CBS_DST_PUSH 7'h0D
`define CBS_OP_OR 7'h2A
`define CBS_ACC_TO_BIT 4'hF
`define CBS_BIT_TO_C 4'hE
`define CBS_BIT_OR_C 4'hA
`define CBS_C_CONST 4'hD
`define CBS_NEG_HI 4'h8
`define CBS_NEG_SEL 4'h9
`define CBS_C_CLR_SEL 4'h0
`define CBS_C_SET_SEL 4'h1
`define CBS_COND_ALWAYS 4'h8
`define CBS_COND_C 4'hA
`define CBS_COND_NC 4'hE
`define CBS_COND_Z 4'h9
`define CBS_COND_NZ 4'hD
`define CBS_COND_S 4'hC
`define CBS_PFX_LOW 3'h0
`define CBS_PFX_BANK 3'h2
`endif

//--- core/cbs_pkg.sv
// types shared by the instruction slice and its bus
`include "cbs_map.svh"
package cbs_pkg;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cbs_apb_req_s;
  // apb answer from this block
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cbs_apb_rsp_s;
  // whole state of the core slice
  typedef struct packed {
    logic [`CBS_NUM_ACC-1:0][15:0] acc;
    logic [3:0] ap;
    logic c;
    logic s;
    logic z;
    logic e;
    logic [`CBS_STK_DEPTH-1:0][15:0] stack;
    logic [`CBS_SP_W-1:0] sp;
    logic [15:0] ip;
    logic in_service_flag;
    logic [`CBS_NUM_PFX-1:0][7:0] prefix_register;
    logic pfx_vld;
    logic [2:0] pfx_idx;
    logic [`CBS_NUM_MOD-1:0][`CBS_MOD_REGS-1:0][15:0] modr;
    logic [`CBS_SYS_REGS-1:0][7:0] sysr;
    logic exec_en;
    logic irq_ack;
    logic illegal;
    cbs_apb_rsp_s apb;
  } cbs_state_s;
endpackage : cbs_pkg

//--- core/cbs_core.sv
// carry/bit moves, or, negate, stack and return slice of a 16-bit core
`include "cbs_map.svh"
module cbs_core (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // instruction fetch
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  // interrupt request
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vector,
  // apb slave
  input wire cbs_pkg::cbs_apb_req_s i_apb,
  output cbs_pkg::cbs_apb_rsp_s o_apb,
  // core status
  output logic [15:0] o_ip,
  output logic o_in_service,
  output logic o_irq_ack,
  output logic o_illegal
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  cbs_pkg::cbs_state_s state_reg;
  cbs_pkg::cbs_state_s state_next;

  // module 0-5 or system module 8 code
  function automatic logic mod_ok(input logic [3:0] nib);
    mod_ok = (!nib[3] && (nib[2:0] <= `CBS_LAST_MOD)) || (nib == `CBS_SYS_MOD);
  endfunction : mod_ok

  // flags packed as the flags register reads them
  function automatic logic [7:0] psf_byte(input cbs_pkg::cbs_state_s st);
    psf_byte = 8'h00;
    psf_byte[`CBS_PSF_E] = st.e;
    psf_byte[`CBS_PSF_C] = st.c;
    psf_byte[`CBS_PSF_Z] = st.z;
    psf_byte[`CBS_PSF_S] = st.s;
  endfunction : psf_byte

  // register read in module nib at index idx
  function automatic logic [15:0] mod_read(input cbs_pkg::cbs_state_s st,
                                           input logic [3:0] nib,
                                           input logic [3:0] idx);
    mod_read = 16'h0000;
    if (nib == `CBS_SYS_MOD) begin
      if (idx == `CBS_SYS_AP) begin
        mod_read = {12'h000, st.ap};
      end else if (idx == `CBS_SYS_PSF) begin
        mod_read = {8'h00, psf_byte(st)};
      end else begin
        mod_read = {8'h00, st.sysr[idx]};
      end
    end else if (mod_ok(nib)) begin
      mod_read = st.modr[nib[2:0]][idx];
    end
  endfunction : mod_read

  // source operand; byte immediates take a loaded prefix as high byte
  function automatic logic [15:0] read_src(input cbs_pkg::cbs_state_s st,
                                           input logic f,
                                           input logic [7:0] sel);
    logic [7:0] hi;
    hi = st.pfx_vld ? st.prefix_register[st.pfx_idx] : 8'h00;
    read_src = 16'h0000;
    if (!f) begin
      read_src = {hi, sel};
    end else if (mod_ok(sel[3:0])) begin
      read_src = mod_read(st, sel[3:0], sel[7:4]);
    end else if (sel[3:0] == `CBS_NIB_ACCREG) begin
      read_src = st.acc[sel[7:4]];
    end else if ((sel == `CBS_SRC_ACC) || (sel == `CBS_SRC_ACC_NOAP)) begin
      read_src = st.acc[st.ap];
    end
  endfunction : read_src

  // destination write with the flag effect of a plain move
  function automatic cbs_pkg::cbs_state_s write_dst(
      input cbs_pkg::cbs_state_s st, input logic [6:0] dst,
      input logic [15:0] val, input logic bank_hi);
    cbs_pkg::cbs_state_s w;
    logic [3:0] idx;
    w = st;
    idx = {1'b0, dst[6:4]};
    if (dst == `CBS_DST_NUL) begin
      w = st; // bit bucket
    end else if (dst[3:0] == `CBS_SYS_MOD) begin
      if (idx == `CBS_SYS_AP) begin
        w.ap = val[3:0];
        w.s = st.acc[val[3:0]][15];
        w.z = (st.acc[val[3:0]] == 16'h0000);
      end else if (idx == `CBS_SYS_PSF) begin
        w.c = val[`CBS_PSF_C];
        w.e = val[`CBS_PSF_E];
      end else begin
        w.sysr[idx] = val[7:0];
      end
    end else if (mod_ok(dst[3:0])) begin
      w.modr[dst[2:0]][idx] = val;
    end else if (dst == `CBS_DST_ACC) begin
      // active accumulator: sign and zero follow the new word
      w.acc[st.ap] = val;
      w.s = val[15];
      w.z = (val == 16'h0000);
    end else if (dst[3:0] == `CBS_NIB_ACCREG) begin
      // prefix 2 moves the 3-bit code onto the upper bank
      w.acc[{bank_hi, dst[6:4]}] = val;
    end else if (dst[3:0] == `CBS_NIB_PFX) begin
      w.prefix_register[dst[6:4]] = val[7:0];
      w.pfx_vld = 1'b1;
      w.pfx_idx = dst[6:4];
    end
    write_dst = w;
  endfunction : write_dst

  // destination codes the move path knows
  function automatic logic dst_ok(input logic [6:0] dst);
    dst_ok = mod_ok(dst[3:0]) || (dst[3:0] == `CBS_NIB_ACCREG) ||
             (dst[3:0] == `CBS_NIB_PFX) || (dst == `CBS_DST_NUL) ||
             (dst == `CBS_DST_ACC);
  endfunction : dst_ok

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [15:0] acc;
    logic [15:0] val;
    logic [15:0] res;
    logic [3:0] bsel;
    logic [3:0] hi_nib;
    logic take;
    logic bank_hi;
    logic [`CBS_SP_W-1:0] sp_up;
    acc = state_reg.acc[state_reg.ap];
    val = 16'h0000;
    res = 16'h0000;
    bsel = i_instr[7:4];
    hi_nib = i_instr[15:12];
    take = 1'b0;
    bank_hi = state_reg.pfx_vld && (state_reg.pfx_idx == `CBS_PFX_BANK);
    sp_up = state_reg.sp + `CBS_SP_W'(1);
    state_next = state_reg;
    state_next.irq_ack = 1'b0;
    state_next.illegal = 1'b0;

    // apb: one wait cycle, then pready; writes land at the pready edge
    if (i_apb.psel && i_apb.penable) begin
      if (!state_reg.apb.pready) begin
        state_next.apb.pready = 1'b1;
        state_next.apb.pslverr = 1'b0;
        state_next.apb.prdata = 32'h0000_0000;
        case (i_apb.paddr)
          `CBS_OFS_CTRL: begin
            state_next.apb.prdata[`CBS_CTRL_EXEC] = state_reg.exec_en;
          end
          `CBS_OFS_STATUS: begin
            // flags at [11:8] in the order S Z C E
            state_next.apb.prdata = {7'h00, state_reg.in_service_flag,
                                     3'h0, state_reg.sp, 4'h0,
                                     state_reg.s, state_reg.z,
                                     state_reg.c, state_reg.e,
                                     4'h0, state_reg.ap};
          end
          `CBS_OFS_IP: begin
            state_next.apb.prdata = {16'h0000, state_reg.ip};
          end
          `CBS_OFS_ACC: begin
            state_next.apb.prdata = {16'h0000, acc};
          end
          default: begin
            state_next.apb.pslverr = 1'b1; // unmapped
          end
        endcase
        // only the control word is writable
        if (i_apb.pwrite && (i_apb.paddr != `CBS_OFS_CTRL)) begin
          state_next.apb.pslverr = 1'b1;
        end
      end else begin
        state_next.apb.pready = 1'b0;
        state_next.apb.pslverr = 1'b0;
        if (i_apb.pwrite && (i_apb.paddr == `CBS_OFS_CTRL)) begin
          state_next.exec_en = i_apb.pwdata[`CBS_CTRL_EXEC];
        end
      end
    end else begin
      state_next.apb.pready = 1'b0;
      state_next.apb.pslverr = 1'b0;
    end

    // interrupt wins over the fetched word, which is fetched again later
    if (state_reg.exec_en && i_irq_req && !state_reg.in_service_flag) begin
      state_next.sp = sp_up;
      state_next.stack[sp_up] = state_reg.ip;
      state_next.ip = i_irq_vector;
      state_next.in_service_flag = 1'b1;
      state_next.irq_ack = 1'b1;
    end else if (state_reg.exec_en && i_instr_valid) begin
      // a prefix lives for exactly one following instruction
      state_next.pfx_vld = 1'b0;
      state_next.ip = state_reg.ip + 16'h0001;
      if ((i_instr[11:8] == `CBS_NIB_IPDST) &&
          (i_instr[6:0] == `CBS_LOW_STK)) begin
        // returns: subroutine (bit 7 low) or interrupt (bit 7 high)
        case (hi_nib)
          `CBS_COND_ALWAYS: take = 1'b1;
          `CBS_COND_C: take = state_reg.c;
          `CBS_COND_NC: take = !state_reg.c;
          `CBS_COND_Z: take = state_reg.z;
          `CBS_COND_NZ: take = !state_reg.z;
          `CBS_COND_S: take = state_reg.s;
          default: state_next.illegal = 1'b1;
        endcase
        if (take) begin
          state_next.ip = state_reg.stack[state_reg.sp];
          state_next.sp = state_reg.sp - `CBS_SP_W'(1);
          if (i_instr[7]) begin
            state_next.in_service_flag = 1'b0;
          end
        end
      end else if (i_instr[15] && (i_instr[11:8] == `CBS_NIB_ACCOP) &&
                   (i_instr[3:0] == `CBS_NIB_ACCOP)) begin
        // accumulator bit and carry group
        case (i_instr[15:12])
          `CBS_ACC_TO_BIT: begin
            res = acc;
            res[bsel] = state_reg.c;
            state_next.acc[state_reg.ap] = res;
            state_next.s = res[15];
            state_next.z = (res == 16'h0000);
          end
          `CBS_BIT_TO_C: state_next.c = acc[bsel];
          `CBS_BIT_OR_C: state_next.c = state_reg.c | acc[bsel];
          `CBS_C_CONST: begin
            if (bsel == `CBS_C_CLR_SEL) begin
              state_next.c = 1'b0;
            end else if (bsel == `CBS_C_SET_SEL) begin
              state_next.c = 1'b1;
            end else begin
              state_next.illegal = 1'b1;
            end
          end
          `CBS_NEG_HI: begin
            if (bsel == `CBS_NEG_SEL) begin
              res = 16'(~acc + 16'h0001);
              state_next.acc[state_reg.ap] = res;
              state_next.s = res[15];
              state_next.z = (res == 16'h0000);
            end else begin
              state_next.illegal = 1'b1;
            end
          end
          default: state_next.illegal = 1'b1;
        endcase
      end else if (i_instr[14:8] == `CBS_OP_OR) begin
        // the accumulator may not be its own source
        if (i_instr[15] && ((i_instr[7:0] == `CBS_SRC_ACC) ||
            (i_instr[7:0] == `CBS_SRC_ACC_NOAP) ||
            ((i_instr[3:0] == `CBS_NIB_ACCREG) &&
             (i_instr[7:4] == state_reg.ap)))) begin
          state_next.illegal = 1'b1;
        end else begin
          res = acc | read_src(state_reg, i_instr[15], i_instr[7:0]);
          state_next.acc[state_reg.ap] = res;
          state_next.s = res[15];
          state_next.z = (res == 16'h0000);
        end
      end else if (i_instr[14:8] == `CBS_DST_PUSH) begin
        // source is read before the stack moves, so the old top is seen
        val = read_src(state_reg, i_instr[15], i_instr[7:0]);
        state_next.sp = sp_up;
        state_next.stack[sp_up] = val;
      end else if (i_instr[15] && (i_instr[6:0] == `CBS_LOW_STK)) begin
        val = state_reg.stack[state_reg.sp];
        state_next = write_dst(state_next, i_instr[14:8], val,
                               bank_hi);
        state_next.sp = state_reg.sp - `CBS_SP_W'(1);
        if (i_instr[7]) begin
          state_next.in_service_flag = 1'b0;
        end
      end else if (i_instr[15] && (i_instr[3:0] == `CBS_NIB_BITOP) &&
                   mod_ok(i_instr[11:8])) begin
        val = mod_read(state_reg, i_instr[11:8], {1'b0, i_instr[14:12]});
        val[i_instr[6:4]] = i_instr[7];
        state_next = write_dst(state_next, i_instr[14:8], val, 1'b0);
      end else if (i_instr[11:8] == `CBS_NIB_BITOP) begin
        if (i_instr[15] && mod_ok(i_instr[3:0])) begin
          val = mod_read(state_reg, i_instr[3:0], i_instr[7:4]);
          state_next.c = val[i_instr[14:12]];
        end else begin
          state_next.illegal = 1'b1;
        end
      end else if (dst_ok(i_instr[14:8])) begin
        // plain move: byte immediate widened by a loaded prefix
        val = read_src(state_reg, i_instr[15], i_instr[7:0]);
        state_next = write_dst(state_next, i_instr[14:8], val, bank_hi);
      end else begin
        // opcodes outside this slice advance and are flagged
        state_next.illegal = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes everything except the reset, which acts with enable low

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= '0;
      state_reg.exec_en <= `CBS_CTRL_RST;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign o_apb = state_reg.apb;
  assign o_ip = state_reg.ip;
  assign o_in_service = state_reg.in_service_flag;
  assign o_irq_ack = state_reg.irq_ack;
  assign o_illegal = state_reg.illegal;

endmodule : cbs_core

//--- testbench/cbs_core_chk.sv
// port assertions for the bit, stack and return slice
module cbs_core_chk (
  // clock and control
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // instruction fetch and interrupt request
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vector,
  // register bus
  input wire cbs_pkg::cbs_apb_req_s i_apb,
  input wire cbs_pkg::cbs_apb_rsp_s o_apb,
  // core status
  input wire logic [15:0] o_ip,
  input wire logic o_in_service,
  input wire logic o_irq_ack,
  input wire logic o_illegal
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////////////
  // a word that executes: no interrupt competes for the same edge
  wire logic go = i_ce && i_instr_valid && !i_irq_req;
  // interrupt acceptance
  ack_pulse_a: assert property (o_irq_ack |=> !o_irq_ack)
    else $error("acknowledge held past one cycle");
  ack_vector_a: assert property (o_irq_ack |-> o_in_service &&
    o_ip == $past(i_irq_vector)) else $error("acknowledge without vector");
  ack_blocked_a: assert property (o_irq_ack |-> !$past(o_in_service))
    else $error("acknowledge while already in service");
  // only an exit word may drop the in-service flag
  ins_hold_a: assert property (o_in_service &&
    !(i_ce && i_instr_valid && i_instr[7:0] == 8'h8D) |=> o_in_service)
    else $error("in-service dropped without exit");
  exit_clear_a: assert property (go && (i_instr == 16'h8C8D ||
    i_instr == 16'h8A8D) |=> !o_in_service)
    else $error("exit left in-service set");
  // push of a byte immediately followed by a plain return
  ret_ip_a: assert property (go && i_instr[15:8] == 8'h0D ##1
    go && i_instr == 16'h8C0D |=> o_ip[7:0] == $past(i_instr[7:0], 2))
    else $error("return did not load pushed word");
  // bus answer timing and refusals
  ready_wait_a: assert property (i_ce && i_apb.psel && i_apb.penable &&
    !o_apb.pready |=> o_apb.pready) else $error("ready not after one wait");
  ready_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready held past one cycle");
  err_map_a: assert property (o_apb.pready && i_apb.paddr[1:0] == 2'b00 |->
    o_apb.pslverr == (i_apb.paddr > 12'h00C ||
    (i_apb.pwrite && i_apb.paddr != 12'h000))) else $error("bad error answer");
  // main scenarios reached
  cover property (o_irq_ack);
  cover property (o_apb.pready && o_apb.pslverr);
  cover property (o_illegal);
endmodule : cbs_core_chk

//--- testbench/test_cpu_bit_stack_return_ops.sv
// self-checking bench for the bit, stack and return slice
module test_cpu_bit_stack_return_ops;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  logic i_instr_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic i_irq_req = 1'b0;
  logic [15:0] i_irq_vector = 16'h0000;
  cbs_pkg::cbs_apb_req_s i_apb = '0;
  cbs_pkg::cbs_apb_rsp_s o_apb;
  logic [15:0] o_ip;
  logic o_in_service, o_irq_ack, o_illegal;
  // reference state of the core
  logic [15:0] m_acc = 16'h0000, m_ip = 16'h0000, m_ret, vec;
  logic m_c = 1'b0, m_s = 1'b0, m_z = 1'b0, m_ins = 1'b0;
  logic [4:0] m_sp = 5'h00;
  int miscompares = 0, num_checks = 0, cyc = 0;
  cbs_core dut_u (.i_clk, .i_srst, .i_ce, .i_instr_valid, .i_instr,
    .i_irq_req, .i_irq_vector, .i_apb, .o_apb, .o_ip, .o_in_service,
    .o_irq_ack, .o_illegal);
  ////////////////////////////////////////////////////////////////////////
  always #5 i_clk = ~i_clk;
  // hang guard, well above the few hundred cycles the tests take
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic void sz();
    m_s = m_acc[15];
    m_z = (m_acc == 16'h0000);
  endfunction : sz
  function automatic logic taken(input logic [3:0] nb);
    case (nb)
      4'hA: return m_c;
      4'hE: return !m_c;
      4'h9: return m_z;
      4'hD: return !m_z;
      4'hC: return m_s;
      default: return 1'b1;
    endcase
  endfunction : taken
  // one word per cycle; valid stays up so words run back to back
  task automatic op(input logic [15:0] w);
    i_instr <= w;
    i_instr_valid <= 1'b1;
    m_ip++;
    @(posedge i_clk);
  endtask : op
  // one bus transfer, held until ready is seen, then an idle cycle
  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    i_instr_valid <= 1'b0;
    i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    i_apb.penable <= 1'b1;
    // look after the edge, so a registered ready is read settled
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_apb.pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    r = o_apb.prdata;
    e = o_apb.pslverr;
    // the edge that samples ready high ends the transfer
    @(posedge i_clk);
    i_apb <= '0;
    @(posedge i_clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask : rd
  // status word, active accumulator and fetch address against the model
  task automatic st();
    rd(12'h004, {7'h00, m_ins, 3'h0, m_sp, 4'h0, m_s, m_z, m_c, 9'h000},
       "status");
    rd(12'h00C, {16'h0000, m_acc}, "acc");
    chk("ip", {16'h0000, m_ip}, {16'h0000, o_ip});
  endtask : st
  task automatic irq_go();
    vec = 16'($urandom);
    i_irq_vector <= vec;
    i_irq_req <= 1'b1;
    @(posedge i_clk);
    i_irq_req <= 1'b0;
    #1;
    chk("ack", 1, o_irq_ack);
    chk("vector", vec, o_ip);
    m_ret = m_ip;
    m_ip = vec;
    m_sp++;
    m_ins = 1'b1;
  endtask : irq_go
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] hi, lo;
    logic [3:0] b, nb;
    logic [2:0] md, r3;
    logic [31:0] r;
    logic e, v;
    logic [15:0] cop [4] = '{16'hDA1A, 16'hDA0A, 16'hC897, 16'hC817};
    logic [3:0] cn [5] = '{4'hA, 4'hE, 4'h9, 4'hD, 4'hC};
    void'($urandom(5));
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    // reset values, refusals, execution stop
    rd(12'h000, 32'h1, "ctrl");
    st();
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk("unmapped err", 1, e);
    apb(1'b1, 12'h004, 32'hFFFFFFFF, r, e);
    chk("ro write err", 1, e);
    apb(1'b1, 12'h000, 32'h0, r, e);
    op(16'hDA1A);
    m_ip--;
    st();
    apb(1'b1, 12'h000, 32'h1, r, e);
    // clock enable low freezes the core
    i_ce <= 1'b0;
    op(16'hDA1A);
    m_ip--;
    i_ce <= 1'b1;
    i_instr_valid <= 1'b0;
    st();
    $display("test registers done");
    // carry constants and flag-register bit ops
    foreach (cop[i]) begin
      op(cop[i]);
      m_c = !i[0];
      st();
    end
    // accumulator bit moves, negate, prefixed or
    for (int k = 0; k < 8; k++) begin
      hi = (k == 0) ? 8'h80 : 8'($urandom);
      lo = (k == 0) ? 8'h00 : 8'($urandom);
      op({8'h0B, hi});
      op({8'h0A, lo});
      m_acc = {hi, lo};
      b = 4'($urandom);
      op({8'hEA, b, 4'hA});
      m_c = m_acc[b];
      b = 4'($urandom);
      op({8'hAA, b, 4'hA});
      m_c = m_c | m_acc[b];
      b = 4'($urandom);
      op({8'hFA, b, 4'hA});
      m_acc[b] = m_c;
      op(16'h8A9A);
      m_acc = ~m_acc + 16'h0001;
      hi = (k == 1) ? 8'h00 : 8'($urandom);
      lo = (k == 1) ? 8'h00 : 8'($urandom);
      op({8'h0B, hi});
      op({8'h2A, lo});
      m_acc = m_acc | {hi, lo};
      sz();
      st();
    end
    $display("test accumulator done");
    // module register bits set, read back into carry, cleared
    for (int k = 0; k < 4; k++) begin
      md = 3'($urandom_range(5, 0));
      r3 = 3'($urandom);
      b[2:0] = 3'($urandom);
      for (int j = 1; j >= 0; j--) begin
        op({1'b1, r3, 1'b0, md, 1'(j), b[2:0], 4'h7});
        op({1'b1, b[2:0], 4'h7, 1'b0, r3, 1'b0, md});
        m_c = 1'(j);
        st();
      end
    end
    op(16'h8706);
    #1;
    chk("illegal", 1, o_illegal);
    $display("test module bits done");
    // push, pop, plain and conditional returns
    for (int k = 0; k < 10; k++) begin
      hi = (k % 2) ? 8'h80 : 8'h00;
      lo = (k % 3) ? 8'($urandom) : 8'h00;
      op({8'h0B, hi});
      op({8'h0D, lo});
      m_sp++;
      op(16'h8A0D);
      m_sp--;
      m_acc = {hi, lo};
      sz();
      v = 1'($urandom);
      op(v ? 16'hDA1A : 16'hDA0A);
      m_c = v;
      lo = 8'($urandom);
      op({8'h0D, lo});
      m_sp++;
      nb = (k < 5) ? cn[k] : cn[k - 5];
      op({nb, 12'hC0D});
      if (taken(nb)) begin
        m_ip = {8'h00, lo};
        m_sp--;
      end
      st();
    end
    lo = 8'($urandom);
    op({8'h0D, lo});
    op(16'h8C0D);
    m_ip = {8'h00, lo};
    st();
    $display("test stack done");
    // interrupt, blocked request, exits
    irq_go();
    i_irq_req <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_irq_req <= 1'b0;
    op(16'hDA0A);
    m_c = 1'b0;
    op(16'hAC8D);
    st();
    op(16'hDA1A);
    m_c = 1'b1;
    op(16'hAC8D);
    m_ip = m_ret;
    m_sp--;
    m_ins = 1'b0;
    st();
    irq_go();
    op(16'h8A8D);
    m_acc = m_ret;
    sz();
    m_sp--;
    m_ins = 1'b0;
    st();
    irq_go();
    op(16'h8C8D);
    m_ip = m_ret;
    m_sp--;
    m_ins = 1'b0;
    st();
    $display("test interrupt done");
    complete_run();
  end
endmodule : test_cpu_bit_stack_return_ops
bind cbs_core cbs_core_chk chk_u (.i_clk, .i_srst, .i_ce, .i_instr_valid,
  .i_instr, .i_irq_req, .i_irq_vector, .i_apb, .o_apb, .o_ip,
  .o_in_service, .o_irq_ack, .o_illegal);
